// ---- lp_ability_defs.svh ----
// constants for the link partner ability register block
`ifndef LP_ABILITY_DEFS_SVH
`define LP_ABILITY_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define ADDR_W             8
`define IDX_W              6
`define IDX_PARTNER        6'h05
`define IDX_EXPANSION      6'h06
`define IDX_CONTROL        6'h10
`define IDX_INT_STATUS     6'h20
`define IDX_INT_MASK       6'h21
`define IDX_SELECTOR_STAT  6'h22

// ----------------------------------------------------------------
// partner ability word fields
// ----------------------------------------------------------------
`define BIT_NEXT_PAGE      15
`define BIT_ACK            14
`define BIT_REMOTE_FAULT   13
`define RSVD_HI            12
`define RSVD_LO            9
`define TAF_HI             8
`define TAF_LO             5
`define SEL_HI             4
`define SEL_LO             0
`define CW_HI              3
`define CW_LO              0
`define SEL_IEEE_8023      5'h01
`define SEL_IEEE_8029      5'h02
`define ABILITY_RESET      16'h0000

// ----------------------------------------------------------------
// other fields
// ----------------------------------------------------------------
`define BIT_PAGE_RECEIVED  1
`define BIT_OVERRIDE       15
`define INT_W              3
`define EV_PAGE            0
`define EV_FAULT           1
`define EV_BAD_SEL         2
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`define WORD_ZERO          32'h0000_0000

`endif

// ---- lp_ability_pkg.sv ----
// types shared by the link partner ability register block
`default_nettype none
package lp_ability_pkg;
`include "lp_ability_defs.svh"

	typedef enum logic [0:0]
	{
		WR_IDLE = 1'b0,
		WR_RESP = 1'b1
	} wr_state_e;

	typedef struct packed
	{
		logic [15:0] ability;
	} capture_s;

	typedef struct packed
	{
		wr_state_e             wr_state;
		logic                  aw_held;
		logic [`ADDR_W-1:0]    aw_addr;
		logic                  w_held;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic                  override;
		logic                  page_received;
		logic [`INT_W-1:0]     int_status;
		logic [`INT_W-1:0]     int_mask;
	} slave_s;

endpackage
`default_nettype wire

// ---- partner_word_capture.sv ----
// holding register for the received partner base page
`timescale 1ns/1ps
`default_nettype none
`include "lp_ability_defs.svh"

module partner_word_capture
	import lp_ability_pkg::*;
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic                   page_valid,
	input  wire logic [15:0]            page_word,
	input  wire logic                   cw_write,
	input  wire logic [`CW_HI:`CW_LO]   cw_data,
	output logic      [15:0]            ability
);

	capture_s s;
	capture_s next_s;

	// ------------------------------------------------------------
	// load from the link, or a permitted management override
	// ------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		if (page_valid)
		begin
			// a fresh page wins over a same-cycle override write
			next_s.ability = page_word;
			next_s.ability[`RSVD_HI:`RSVD_LO] = '0;
		end
		else if (cw_write)
		begin
			// only the selector low bits may be overridden
			next_s.ability[`CW_HI:`CW_LO] = cw_data;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '{ability: `ABILITY_RESET};
		else
			s <= next_s;
	end

	assign ability = s.ability;

endmodule
`default_nettype wire

// ---- lp_ability_regs.sv ----
// partner ability register bank with an axi4-lite slave
//
// Overview of operation
// - The register is loaded from each base code word the partner sends.
// - Bit 15 shows the partner next-page flag, one meaning more pages follow.
// - Bit 14 shows the partner acknowledge of our own code word.
// - Bit 13 reads one when the partner reports a link fault.
// - Bits 8 to 5 show the partner 100TX-full, 100TX-half, 10T-full, 10T-half abilities.
// - Bit 9, the unsupported T4 ability, always reads zero.
// - Reserved bits 12 to 10 always read zero.
// - Bits 4 to 0 hold the partner selector, with 00001b the supported encoding.
// - The selector decode recognises 00001b and 00010b as defined codes.
// - Every stored partner word sets the latching page-received expansion bit.
// - Override-writable bits accept writes only while the override bit is one.
//
// register map, byte address = word index * 4
//   0x14  partner ability word, read only apart from override bits 3:0
//   0x18  expansion, bit 1 page received, latch high, cleared by its own read
//   0x40  control, bit 15 override enable, written through byte lane 1
//   0x80  interrupt status, bit 0 page, bit 1 remote fault, bit 2 foreign selector
//   0x84  interrupt mask, same layout, zero after reset
//   0x88  selector status, bit 0 ieee 802.3 code, bit 1 ieee 802.9 code
//   other words answer slverr; reads return zero and writes are dropped
//
// bus timing
//   read answer registered one edge after the address is taken
//   write answer one cycle after address and data are both held
//   address and data are taken in either order, each in its own slot
//   prot inputs are ignored; the map has no privileged split
//
// limitations
//   one write and one read in flight; later beats stall on ready
//   a page and an override write in one cycle: the page wins, the write is lost
//   interrupt status and page received: a new event beats a same-cycle clear
//   negotiation completion is flagged elsewhere; until then the word may be stale
`timescale 1ns/1ps
`default_nettype none
`include "lp_ability_defs.svh"

module lp_ability_regs
	import lp_ability_pkg::*;
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// partner base page from the code-word receiver
	input  wire logic                   page_valid,
	input  wire logic [15:0]            page_word,
	// axi4-lite slave
	input  wire logic [`ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`ADDR_W-1:0]     s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// decoded partner state and interrupt
	output logic                        sel_ieee_8023,
	output logic                        sel_ieee_8029,
	output logic                        irq
);

	slave_s                   s;
	slave_s                   next_s;
	logic [15:0]              ability;
	logic                     wr_fire;
	logic                     cw_write;
	logic [`INT_W-1:0]        events;
	logic [1:0]               page_sel;
	logic [1:0]               stored_sel;
	logic [31:0]              mask_merged;

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------

	// word decode, shared by the read and write paths
	function automatic logic reg_hit(input logic [`ADDR_W-1:0] addr,
		input logic [`IDX_W-1:0] idx);
		return addr[`ADDR_W-1:2] == idx;
	endfunction

	// byte-lane merge for writable words
	function automatic logic [31:0] merge_strb(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		end
		return res;
	endfunction

	// selector decode, used for status, interrupts and outputs
	function automatic logic [1:0] sel_decode(input logic [`SEL_HI:`SEL_LO] sel);
		logic [1:0] res;
		res = 2'h0;
		if (sel == `SEL_IEEE_8023)
			res[0] = 1'b1;
		if (sel == `SEL_IEEE_8029)
			res[1] = 1'b1;
		return res;
	endfunction

	// mapped word check, unmapped addresses answer slverr
	function automatic logic mapped(input logic [`ADDR_W-1:0] addr);
		return reg_hit(addr, `IDX_PARTNER) || reg_hit(addr, `IDX_EXPANSION) ||
			reg_hit(addr, `IDX_CONTROL) || reg_hit(addr, `IDX_INT_STATUS) ||
			reg_hit(addr, `IDX_INT_MASK) || reg_hit(addr, `IDX_SELECTOR_STAT);
	endfunction

	// ------------------------------------------------------------
	// partner word holding register
	// ------------------------------------------------------------

	// a write applies only when both slots are full and no answer waits
	// override writes reach only the low selector byte lane
	assign wr_fire  = s.aw_held && s.w_held && (s.wr_state == WR_IDLE);
	assign cw_write = wr_fire && reg_hit(s.aw_addr, `IDX_PARTNER) &&
		s.override && s.w_strb[0];

	partner_word_capture capture
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.page_valid (page_valid),
		.page_word  (page_word),
		.cw_write   (cw_write),
		.cw_data    (s.w_data[`CW_HI:`CW_LO]),
		.ability    (ability)
	);

	// ------------------------------------------------------------
	// shared decodes
	// ------------------------------------------------------------

	// each decode is named once so every user sees the same value
	assign page_sel    = sel_decode(page_word[`SEL_HI:`SEL_LO]);
	assign stored_sel  = sel_decode(ability[`SEL_HI:`SEL_LO]);
	// mask bits padded to a word so the shared lane merge applies
	assign mask_merged = merge_strb({29'h0, s.int_mask}, s.w_data, s.w_strb);

	// ------------------------------------------------------------
	// events from the link side
	// ------------------------------------------------------------

	// page arrival, partner-reported fault, foreign selector
	// one-cycle pulses, made sticky in the status word
	always_comb
	begin
		events = '0;
		events[`EV_PAGE]    = page_valid;
		events[`EV_FAULT]   = page_valid && page_word[`BIT_REMOTE_FAULT];
		// anything but the one supported encoding counts as foreign
		events[`EV_BAD_SEL] = page_valid && !page_sel[0];
	end

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		next_s = s;

		// write address and data are accepted in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_s.w_held = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end

		// write channel state machine
		case (s.wr_state)
			WR_IDLE:
			begin
				// both halves held: apply the write and queue its answer
				if (wr_fire)
				begin
					next_s.aw_held  = 1'b0;
					next_s.w_held   = 1'b0;
					next_s.wr_state = WR_RESP;
					next_s.bresp    = mapped(s.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
					if (reg_hit(s.aw_addr, `IDX_CONTROL) && s.w_strb[1])
						next_s.override = s.w_data[`BIT_OVERRIDE];
					if (reg_hit(s.aw_addr, `IDX_INT_MASK))
						next_s.int_mask = mask_merged[`INT_W-1:0];
					// write one to clear
					if (reg_hit(s.aw_addr, `IDX_INT_STATUS) && s.w_strb[0])
						next_s.int_status = s.int_status & ~s.w_data[`INT_W-1:0];
				end
			end
			WR_RESP:
			begin
				// the answer stands until the master takes it
				if (s_axi_bready)
					next_s.wr_state = WR_IDLE;
			end
			default:
			begin
				// unreachable with a one-bit state, kept for recovery
				next_s.wr_state = WR_IDLE;
			end
		endcase

		// read channel, one outstanding read, data held in a register
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			// unmapped words read zero and answer slverr
			next_s.rvalid = 1'b1;
			next_s.rresp  = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			next_s.rdata  = `WORD_ZERO;
			if (reg_hit(s_axi_araddr, `IDX_PARTNER))
				next_s.rdata[15:0] = ability;
			if (reg_hit(s_axi_araddr, `IDX_EXPANSION))
			begin
				next_s.rdata[`BIT_PAGE_RECEIVED] = s.page_received;
				// latch-high bit clears on read of the expansion word
				next_s.page_received = 1'b0;
			end
			if (reg_hit(s_axi_araddr, `IDX_CONTROL))
				next_s.rdata[`BIT_OVERRIDE] = s.override;
			if (reg_hit(s_axi_araddr, `IDX_INT_STATUS))
				next_s.rdata[`INT_W-1:0] = s.int_status;
			if (reg_hit(s_axi_araddr, `IDX_INT_MASK))
				next_s.rdata[`INT_W-1:0] = s.int_mask;
			if (reg_hit(s_axi_araddr, `IDX_SELECTOR_STAT))
				next_s.rdata[1:0] = stored_sel;
		end

		// link events land last so they override any clear above
		// set wins over a same-cycle clear
		if (page_valid)
			next_s.page_received = 1'b1;
		for (int i = 0; i < `INT_W; i++)
		begin
			if (events[i])
				next_s.int_status[i] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------

	// one register for the whole struct keeps reset in one place
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else
			s <= next_s;
	end

	// ------------------------------------------------------------
	// bus handshakes and outputs
	// ------------------------------------------------------------

	// holding slots stall further beats until the response is taken
	// arready returns only once the read answer is taken
	assign s_axi_awready = !s.aw_held && (s.wr_state == WR_IDLE);
	assign s_axi_wready  = !s.w_held && (s.wr_state == WR_IDLE);
	assign s_axi_bvalid  = (s.wr_state == WR_RESP);
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;

	// decode of the stored selector, from the holding register
	assign sel_ieee_8023 = stored_sel[0];
	assign sel_ieee_8029 = stored_sel[1];

	// level interrupt while any unmasked status bit stands
	// no edge detect: the line stays up until software clears or masks
	assign irq = |(s.int_status & s.int_mask);

endmodule
`default_nettype wire

// ---- ability_props.sv ----
// checker for the partner ability register bank
`timescale 1ns/1ps
`default_nettype none
module ability_props
	import lp_ability_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        page_valid,
	input wire logic [15:0] page_word,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        sel_ieee_8023,
	input wire logic        sel_ieee_8029,
	input wire logic        irq
);
	// ----------------------------------------
	// steps and properties
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence pg_8023;
		page_valid && page_word[4:0] == 5'h01;
	endsequence
	sequence pg_8029;
		page_valid && page_word[4:0] == 5'h02;
	endsequence
	sequence part_rd;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h14;
	endsequence
	// reset itself is watched, so no disable here
	reset_a: assert property (disable iff (1'b0) !aresetn |=>
		!irq && !sel_ieee_8023 && !sel_ieee_8029 && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not cleared by reset");
	sel_8023_a: assert property (pg_8023 |=> sel_ieee_8023 && !sel_ieee_8029)
		else $error("selector 802.3 flag wrong");
	sel_8029_a: assert property (pg_8029 |=> sel_ieee_8029 && !sel_ieee_8023)
		else $error("selector 802.9 flag wrong");
	rsvd_read_a: assert property (part_rd |=> s_axi_rdata[31:16] == 16'h0000
		&& s_axi_rdata[12:9] == 4'h0) else $error("reserved bits read nonzero");
	// only a page or a finished write may move the stored selector
	sel_hold_a: assert property (!$past(page_valid) && !$rose(s_axi_bvalid)
		|-> $stable(sel_ieee_8023) && $stable(sel_ieee_8029)) else $error("selector moved");
	irq_cause_a: assert property ($rose(irq) |-> $past(page_valid)
		|| $rose(s_axi_bvalid)) else $error("irq rose without cause");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
endmodule
bind lp_ability_regs ability_props u_props (.aclk, .aresetn, .page_valid, .page_word,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .sel_ieee_8023,
	.sel_ieee_8029, .irq);
`default_nettype wire

// ---- link_partner_model.sv ----
// behavioural remote link partner sending base pages
`timescale 1ns/1ps
`default_nettype none
module link_partner_model
	import lp_ability_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        send,
	input  wire logic [15:0] word,
	output logic             page_valid,
	output logic [15:0]      page_word
);
	// ----------------------------------------
	// page transmit
	// ----------------------------------------
	// word means nothing off the strobe, so it churns to expose stale use
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			page_valid <= 1'b0;
			page_word <= 16'h0000;
		end
		else
		begin
			page_valid <= send;
			page_word <= send ? word : ~page_word;
		end
	end
endmodule
`default_nettype wire

// ---- autoneg_partner_ability_reg_tb.sv ----
// testbench for the partner ability register bank
`timescale 1ns/1ps
`default_nettype none
module autoneg_partner_ability_reg_tb
	import lp_ability_pkg::*;
;
	logic        aclk, aresetn, send, page_valid, irq, sel_ieee_8023, sel_ieee_8029;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, lf;
	logic [15:0] word, page_word, w, v;
	int          fails, checks;
	logic [7:0]  rst_addr [5] = '{8'h14, 8'h18, 8'h80, 8'h84, 8'h88};
	lp_ability_regs u_dut (.aclk, .aresetn, .page_valid, .page_word, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sel_ieee_8023, .sel_ieee_8029, .irq);
	link_partner_model u_partner (.aclk, .aresetn, .send, .word, .page_valid, .page_word);
	// ----------------------------------------
	// expectations and bus tasks
	// ----------------------------------------
	function automatic logic [31:0] f_ab(input logic [15:0] x);
		return {16'h0000, x & 16'he1ff};
	endfunction
	function automatic logic [31:0] f_sel(input logic [15:0] x);
		return {30'h0, x[4:0] == 5'h02, x[4:0] == 5'h01};
	endfunction
	function automatic logic [31:0] f_int(input logic [15:0] x);
		return {29'h0, x[4:0] != 5'h01, x[13], 1'b1};
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	// ready is raised late so the slave must hold its answer
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		logic ad, wd;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= x;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		ad = 1'b0;
		wd = 1'b0;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic pg(input logic [15:0] x);
		@(posedge aclk);
		send <= 1'b1;
		word <= x;
		@(posedge aclk);
		send <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic results;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// clock, watchdog and tests
	// ----------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial
	begin
		repeat (20000) @(posedge aclk);
		fails++;
		results;
	end
	initial
	begin
		{aresetn, send, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
		{word, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		lf = 32'h0000_88f9;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rst_addr[i])
		begin
			rd(rst_addr[i]);
			chk("reset", d, 32'h0);
		end
		$display("reset test done");
		wr(8'h84, 32'h7);
		for (int i = 0; i < 24; i++)
		begin
			lf = lfsr(lf);
			w = (i == 0) ? 16'hffff : (i == 1) ? 16'h4002 : (i == 2) ? 16'h21e1 : lf[15:0];
			pg(w);
			rd(8'h14);
			chk("ability", d, f_ab(w));
			chk("sel pins", {30'h0, sel_ieee_8029, sel_ieee_8023}, f_sel(w));
			rd(8'h88);
			chk("sel reg", d, f_sel(w));
			rd(8'h18);
			chk("page rx", d, 32'h2);
			rd(8'h18);
			chk("page clr", d, 32'h0);
			rd(8'h80);
			chk("int st", d, f_int(w));
			chk("irq set", {31'h0, irq}, 32'h1);
			wr(8'h80, 32'h7);
			chk("irq clr", {31'h0, irq}, 32'h0);
		end
		$display("page test done");
		wr(8'h14, 32'h0000_000f);
		rd(8'h14);
		chk("ro write", d, f_ab(w));
		wr(8'h40, 32'h0000_8000);
		chk("okay", {30'h0, r}, 32'h0);
		// reserved bits written at their default
		v = (w & 16'he1f0) | 16'h0002;
		wr(8'h14, {16'h0000, v});
		rd(8'h14);
		chk("ovr write", d, f_ab(v));
		chk("ovr sel", {30'h0, sel_ieee_8029, sel_ieee_8023}, f_sel(v));
		wr(8'h40, 32'h0);
		wr(8'h14, {16'h0000, v ^ 16'h0003});
		rd(8'h14);
		chk("locked", d, f_ab(v));
		$display("override test done");
		rd(8'hf0);
		chk("unm data", d, 32'h0);
		chk("unm rresp", {30'h0, r}, 32'h2);
		wr(8'hf0, 32'hffff_ffff);
		chk("unm bresp", {30'h0, r}, 32'h2);
		$display("unmapped test done");
		results;
	end
endmodule
`default_nettype wire
